// ==== src/pmc_pkg.sv ====
// Contract
// - Sleep level 00 idle, 01/10/11 sleep depths
// - Trigger write enters level; reads 0
// - Level 00 trigger halts CPU only
// - Enabled interrupt clears trigger, returns active
// - Port or POR wakes any sleep depth; timer wakes all but deepest
// - Power-down sequence runs before sleep
// - Wake on RC, crystal if select was 0
// - Select 1 at trigger stays on RC
// - One instruction runs before wake ISR
// - Force-reset bit 5 fires watchdog reset
// - CRC result bits 3:2, write zero clears
// - CRC fail after deep wake resets if enabled
// - Trim disable applies after running on RC
// - Status copy follows after slow RC runs
// - Reset cause bits 4:3 hold latest source
// - Status bit 0 is synchronized slow clock
// - System runs on RC until crystal stable
// - Amplitude detector gates crystal use
// - Slow RC trim only while crystal enabled
// - Light sleep stops HF oscillators only
// - Deepest: regulator, oscillators off; port/POR wake
// - Select bit: 0 crystal, 1 RC
package pmc_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [15:0] ADDR_SLEEP_TRIGGER_CTL = 16'h0087;
  localparam logic [15:0] ADDR_SLEEP_MODE_STATUS = 16'h009d;
  localparam logic [15:0] ADDR_SLEEP_MODE_CMD = 16'h00be;
  localparam logic [15:0] ADDR_RETENTION_CRC_CTL = 16'h6262;

  // ==========================================================
  // Field positions
  localparam int TRIG_BIT = 0;
  localparam int CMD_TRIM_DIS_BIT = 7;
  localparam int CMD_RSVD_ONE_BIT = 2;
  localparam int STA_TRIM_DIS_BIT = 7;
  localparam int STA_CAUSE_LSB = 3;
  localparam int STA_SLOW_CLK_BIT = 0;
  localparam int CRC_FORCE_BIT = 5;
  localparam int CRC_RESULT_LSB = 2;
  localparam int CRC_EN_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam logic CMD_RSVD_ONE_RESET = 1'b1;
  localparam logic [6:0] TRIG_RSVD_RESET = 7'h00;
  localparam logic [1:0] CRC_RESULT_RESET = 2'h0;

  // ==========================================================
  // Encodings
  localparam logic [1:0] LEVEL_IDLE = 2'h0;
  localparam logic [1:0] LEVEL_LIGHT = 2'h1;
  localparam logic [1:0] LEVEL_DEEP = 2'h2;
  localparam logic [1:0] LEVEL_DEEPEST = 2'h3;
  localparam logic [1:0] CAUSE_POWER_ON = 2'h0;
  localparam logic [1:0] CRC_PASS = 2'h0;
  localparam logic SEL_CRYSTAL = 1'b0;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PDOWN_TIME_NS = 1000;
  localparam int PDOWN_CYCLES = (PDOWN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PDOWN_CNT_W = 5;

  // ==========================================================
  // Types
  typedef enum logic [5:0] {
    ST_ACTIVE = 6'b000001,
    ST_IDLE = 6'b000010,
    ST_PDOWN = 6'b000100,
    ST_SLEEP = 6'b001000,
    ST_WAKE_RC = 6'b010000,
    ST_XTAL_WAIT = 6'b100000
  } pmc_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pmc_sfr_req_t;

  typedef struct packed {
    logic port_irq;
    logic timer_irq;
    logic any_irq;
    logic por;
  } pmc_wake_t;

  typedef struct packed {
    logic cpu_halt;
    logic pdown_seq;
    logic core_reg_on;
    logic rc_osc_en;
    logic xtal_osc_en;
    logic slow_osc_en;
    logic sysclk_on_xtal;
    logic slow_trim_run;
  } pmc_power_t;

  function automatic logic sfr_hit(input pmc_sfr_req_t req, input logic [15:0] addr);
    return req.addr == addr;
  endfunction

endpackage

// ==== src/pmc_power_mode_ctl.sv ====
`timescale 1ns/100ps
`default_nettype none
module pmc_power_mode_ctl (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register port from the CPU
  input wire pmc_pkg::pmc_sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  // Wake sources and CPU progress
  input wire pmc_pkg::pmc_wake_t i_wake,
  input wire logic i_instr_retired,
  // Clock system
  input wire logic i_sysclk_sel,
  input wire logic i_xtal_stable,
  input wire logic i_slow_clk,
  input wire logic i_slow_src_rc,
  // Reset cause and retention check
  input wire logic [1:0] i_rst_cause,
  input wire logic i_crc_valid,
  input wire logic [1:0] i_crc_result,
  // Power controls
  output pmc_pkg::pmc_power_t o_power,
  output logic o_isr_defer,
  output logic o_wdog_reset
);
  import pmc_pkg::*;

  // ==========================================================
  // State
  pmc_state_t state, next_state;
  logic [1:0] level, next_level;
  logic [1:0] entry_level, next_entry_level;
  logic rsvd_one, next_rsvd_one;
  logic [6:0] trig_rsvd, next_trig_rsvd;
  logic trim_dis_cmd, next_trim_dis_cmd;
  logic trim_dis_eff, next_trim_dis_eff;
  logic trim_dis_sta, next_trim_dis_sta;
  logic [1:0] rst_cause, next_rst_cause;
  logic [1:0] crc_result, next_crc_result;
  logic crc_en, next_crc_en;
  logic sel_at_entry, next_sel_at_entry;
  logic deep_woke, next_deep_woke;
  logic isr_defer, next_isr_defer;
  logic wdog, next_wdog;
  logic [PDOWN_CNT_W-1:0] pd_cnt, next_pd_cnt;
  logic [7:0] rdata, next_rdata;
  logic slow_clock_sync;
  logic wake_sleep;
  logic wr_trig, wr_cmd, wr_crc;

  pmc_sync u_slow_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async(i_slow_clk),
    .o_sync(slow_clock_sync)
  );

  assign wr_trig = i_sfr.wr && sfr_hit(i_sfr, ADDR_SLEEP_TRIGGER_CTL);
  assign wr_cmd = i_sfr.wr && sfr_hit(i_sfr, ADDR_SLEEP_MODE_CMD);
  assign wr_crc = i_sfr.wr && sfr_hit(i_sfr, ADDR_RETENTION_CRC_CTL);

  // ==========================================================
  // Wake qualification
  always_comb begin
    wake_sleep = i_wake.port_irq || i_wake.timer_irq || i_wake.por;
    if (entry_level == LEVEL_DEEPEST) begin
      wake_sleep = i_wake.port_irq || i_wake.por;
    end
  end

  // ==========================================================
  // Mode sequencer
  always_comb begin
    next_state = state;
    next_entry_level = entry_level;
    next_sel_at_entry = sel_at_entry;
    next_pd_cnt = pd_cnt;
    next_deep_woke = deep_woke;
    next_isr_defer = isr_defer;
    // Clears come first, so a wake in the same cycle sets the flag again
    // one instruction before ISR
    if (isr_defer && i_instr_retired) begin
      next_isr_defer = 1'b0;
    end
    // A result consumes the deep-wake mark unless a new wake sets it
    if (deep_woke && i_crc_valid) begin
      next_deep_woke = 1'b0;
    end
    unique case (state)
      ST_ACTIVE: begin
        if (wr_trig && i_sfr.wdata[TRIG_BIT]) begin
          next_entry_level = level;
          next_sel_at_entry = i_sysclk_sel;
          next_pd_cnt = '0;
          next_state = (level == LEVEL_IDLE) ? ST_IDLE : ST_PDOWN;
        end
      end
      ST_IDLE: begin
        if (i_wake.any_irq || i_wake.por) begin
          next_state = ST_ACTIVE;
          next_isr_defer = 1'b1;
        end
      end
      ST_PDOWN: begin
        if (pd_cnt == PDOWN_CNT_W'(PDOWN_CYCLES - 1)) begin
          next_state = ST_SLEEP;
        end else begin
          next_pd_cnt = pd_cnt + PDOWN_CNT_W'(1);
        end
      end
      ST_SLEEP: begin
        if (wake_sleep) begin
          next_state = ST_WAKE_RC;
          next_isr_defer = 1'b1;
          next_deep_woke = entry_level[1];
        end
      end
      ST_WAKE_RC: begin
        next_state = (sel_at_entry == SEL_CRYSTAL) ? ST_XTAL_WAIT : ST_ACTIVE;
      end
      ST_XTAL_WAIT: begin
        if (i_xtal_stable) begin
          next_state = ST_ACTIVE;
        end
      end
      default: next_state = ST_ACTIVE;
    endcase
  end

  // ==========================================================
  // Registers written by software
  always_comb begin
    next_level = level;
    next_rsvd_one = rsvd_one;
    next_trig_rsvd = trig_rsvd;
    next_trim_dis_cmd = trim_dis_cmd;
    next_crc_en = crc_en;
    next_crc_result = crc_result;
    next_wdog = 1'b0;
    if (wr_trig) begin
      next_trig_rsvd = i_sfr.wdata[7:1];
    end
    if (wr_cmd) begin
      next_level = i_sfr.wdata[1:0];
      next_rsvd_one = i_sfr.wdata[CMD_RSVD_ONE_BIT];
      next_trim_dis_cmd = i_sfr.wdata[CMD_TRIM_DIS_BIT];
    end
    if (wr_crc) begin
      next_crc_en = i_sfr.wdata[CRC_EN_BIT];
      next_crc_result = crc_result & i_sfr.wdata[CRC_RESULT_LSB +: 2];
      next_wdog = i_sfr.wdata[CRC_FORCE_BIT];
    end
    // A fresh result from hardware wins over a clearing write
    if (i_crc_valid) begin
      next_crc_result = i_crc_result;
      if (crc_en && deep_woke && (i_crc_result != CRC_PASS)) begin
        next_wdog = 1'b1;
      end
    end
  end

  // ==========================================================
  // Calibration disable and status
  // The effective copy and the status copy follow the command on
  // different conditions, so software may briefly read a stale status.
  always_comb begin
    next_trim_dis_eff = trim_dis_eff;
    next_trim_dis_sta = trim_dis_sta;
    next_rst_cause = rst_cause;
    // applies once system runs on RC
    if (!o_power.sysclk_on_xtal) begin
      next_trim_dis_eff = trim_dis_cmd;
    end
    if (i_slow_src_rc && o_power.slow_osc_en) begin
      next_trim_dis_sta = trim_dis_cmd;
    end
    if (i_rst) begin
      next_rst_cause = i_rst_cause;
    end
  end

  // ==========================================================
  // Read data
  always_comb begin
    next_rdata = 8'h00;
    if (i_sfr.rd) begin
      if (sfr_hit(i_sfr, ADDR_SLEEP_TRIGGER_CTL)) begin
        next_rdata = {trig_rsvd, 1'b0};
      end else if (sfr_hit(i_sfr, ADDR_SLEEP_MODE_CMD)) begin
        next_rdata = {trim_dis_cmd, 4'h0, rsvd_one, level};
      end else if (sfr_hit(i_sfr, ADDR_SLEEP_MODE_STATUS)) begin
        next_rdata[STA_TRIM_DIS_BIT] = trim_dis_sta;
        next_rdata[STA_CAUSE_LSB +: 2] = rst_cause;
        next_rdata[STA_SLOW_CLK_BIT] = slow_clock_sync;
      end else if (sfr_hit(i_sfr, ADDR_RETENTION_CRC_CTL)) begin
        next_rdata[CRC_RESULT_LSB +: 2] = crc_result;
        next_rdata[CRC_EN_BIT] = crc_en;
      end
    end
  end

  // ==========================================================
  // Flip-flops
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state <= ST_ACTIVE;
      level <= LEVEL_RESET;
      entry_level <= LEVEL_RESET;
      rsvd_one <= CMD_RSVD_ONE_RESET;
      trig_rsvd <= TRIG_RSVD_RESET;
      trim_dis_cmd <= 1'b0;
      trim_dis_eff <= 1'b0;
      trim_dis_sta <= 1'b0;
      crc_result <= CRC_RESULT_RESET;
      crc_en <= 1'b0;
      sel_at_entry <= 1'b1;
      deep_woke <= 1'b0;
      isr_defer <= 1'b0;
      wdog <= 1'b0;
      pd_cnt <= '0;
      rdata <= 8'h00;
    end else begin
      state <= next_state;
      level <= next_level;
      entry_level <= next_entry_level;
      rsvd_one <= next_rsvd_one;
      trig_rsvd <= next_trig_rsvd;
      trim_dis_cmd <= next_trim_dis_cmd;
      trim_dis_eff <= next_trim_dis_eff;
      trim_dis_sta <= next_trim_dis_sta;
      crc_result <= next_crc_result;
      crc_en <= next_crc_en;
      sel_at_entry <= next_sel_at_entry;
      deep_woke <= next_deep_woke;
      isr_defer <= next_isr_defer;
      wdog <= next_wdog;
      pd_cnt <= next_pd_cnt;
      rdata <= next_rdata;
    end
  end

  // Cause capture is clocked during reset, so it is kept out of the reset branch
  always_ff @(posedge i_core_clk) begin
    rst_cause <= next_rst_cause;
  end

  // ==========================================================
  // Power controls decoded from state
  // Decoded from registered state plus the select, stability and slow-source inputs, so the enables never glitch
  // on a register write; the price is one cycle of lag after a wake.
  // Regulator, RC and slow oscillators stay on outside sleep by default.
  always_comb begin
    o_power.cpu_halt = (state != ST_ACTIVE) || wdog;
    o_power.pdown_seq = state == ST_PDOWN;
    o_power.core_reg_on = 1'b1;
    o_power.rc_osc_en = 1'b1;
    o_power.slow_osc_en = 1'b1;
    // RC carries the clock until crystal ready
    o_power.xtal_osc_en = (state == ST_XTAL_WAIT) ||
                          ((state != ST_SLEEP) && (i_sysclk_sel == SEL_CRYSTAL));
    // select 0 crystal, gated by stability
    o_power.sysclk_on_xtal = o_power.xtal_osc_en && i_xtal_stable &&
                             (state != ST_XTAL_WAIT) && (state != ST_WAKE_RC);
    if (state == ST_SLEEP) begin
      o_power.rc_osc_en = 1'b0;
      o_power.core_reg_on = !entry_level[1];
      o_power.slow_osc_en = entry_level != LEVEL_DEEPEST;
    end
    o_power.slow_trim_run = o_power.xtal_osc_en && !trim_dis_eff && i_slow_src_rc;
  end

  assign o_sfr_rdata = rdata;
  assign o_isr_defer = isr_defer;
  assign o_wdog_reset = wdog;
endmodule
`default_nettype wire

// ==== src/pmc_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module pmc_sync (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Level
  input wire logic i_async,
  output logic o_sync
);
  logic meta;
  logic next_meta;
  logic next_sync;

  always_comb begin
    next_meta = i_async;
    next_sync = meta;
  end

  // The first stage feeds only the second stage
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      meta <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta <= next_meta;
      o_sync <= next_sync;
    end
  end
endmodule
`default_nettype wire

// ==== tb/pmc_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
module pmc_partner #(
  parameter int XTAL_DLY = 6
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // From the block
  input wire logic i_xtal_en,
  input wire logic i_isr_defer,
  // To the block
  output logic o_xtal_stable,
  output logic o_instr_retired
);
  int xcnt;
  int icnt;
  // ==========================================================
  // Crystal needs time to settle after each enable
  always_ff @(posedge i_core_clk) begin
    xcnt <= (i_rst || !i_xtal_en) ? 0 : (xcnt < XTAL_DLY) ? xcnt + 1 : xcnt;
  end
  assign o_xtal_stable = (xcnt == XTAL_DLY);
  // ==========================================================
  // CPU retires the single instruction after the trigger
  // no link engine here, so nothing to park
  always_ff @(posedge i_core_clk) begin
    icnt <= (i_rst || !i_isr_defer) ? 0 : icnt + 1;
  end
  assign o_instr_retired = (icnt == 2);
endmodule
`default_nettype wire

// ==== tb/pmc_power_mode_ctl_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module pmc_power_mode_ctl_tb_top;
  import pmc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pmc_sfr_req_t sfr = '0;
  pmc_wake_t wake = '0;
  logic sel = 1'b1;
  logic slow = 1'b0;
  logic slow_rc = 1'b1;
  logic [1:0] cause = 2'h3;
  logic crc_v = 1'b0;
  logic [1:0] crc_r = 2'h0;
  logic [7:0] rdata;
  pmc_power_t pw;
  logic defer, wd, xstab, retired;
  int err_count = 0;
  int checks = 0;
  int wd_cnt = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (wd === 1'b1) wd_cnt <= wd_cnt + 1;
  pmc_power_mode_ctl u_dut (
    .i_core_clk(clk), .i_rst(rst), .i_sfr(sfr), .o_sfr_rdata(rdata), .i_wake(wake),
    .i_instr_retired(retired), .i_sysclk_sel(sel), .i_xtal_stable(xstab),
    .i_slow_clk(slow), .i_slow_src_rc(slow_rc), .i_rst_cause(cause), .i_crc_valid(crc_v),
    .i_crc_result(crc_r), .o_power(pw), .o_isr_defer(defer), .o_wdog_reset(wd)
  );
  pmc_partner u_partner (
    .i_core_clk(clk), .i_rst(rst), .i_xtal_en(pw.xtal_osc_en), .i_isr_defer(defer),
    .o_xtal_stable(xstab), .o_instr_retired(retired)
  );
  // ==========================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    sfr <= '0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    sfr <= '0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs(input logic [7:0] sta);
    logic [7:0] d;
    rd(ADDR_SLEEP_MODE_CMD, d); chk(d, 8'h04, "cmd reset");
    wr(ADDR_SLEEP_MODE_STATUS, 8'hff);
    rd(ADDR_SLEEP_MODE_STATUS, d); chk(d, sta, "status");
    rd(16'h1234, d); chk(d, 8'h00, "unmapped");
    wr(ADDR_SLEEP_TRIGGER_CTL, 8'hfe);
    rd(ADDR_SLEEP_TRIGGER_CTL, d); chk(d, 8'hfe, "trig");
    wr(ADDR_SLEEP_TRIGGER_CTL, 8'h00);
    wr(ADDR_SLEEP_MODE_CMD, 8'h7f);
    rd(ADDR_SLEEP_MODE_CMD, d); chk(d, 8'h07, "cmd mask");
    wr(ADDR_SLEEP_MODE_CMD, 8'h04);
    $display("regs done");
  endtask
  task automatic t_idle();
    logic [7:0] d;
    wr(ADDR_SLEEP_TRIGGER_CTL, 8'h01);
    rd(ADDR_SLEEP_TRIGGER_CTL, d); chk(d, 8'h00, "trig reads 0");
    chk({5'h0, pw.cpu_halt, pw.rc_osc_en, pw.pdown_seq}, 8'h06, "idle");
    @(posedge clk); wake.any_irq <= 1'b1;
    @(posedge clk); wake.any_irq <= 1'b0;
    @(negedge clk); chk({6'h0, pw.cpu_halt, defer}, 8'h01, "idle wake");
    cyc(5); chk({7'h0, defer}, 8'h00, "defer end");
    $display("idle done");
  endtask
  task automatic t_sleep(input logic [1:0] lv, input logic s);
    int n;
    @(posedge clk); sel <= s;
    wr(ADDR_SLEEP_MODE_CMD, {6'h01, lv});
    wr(ADDR_SLEEP_TRIGGER_CTL, 8'h01);
    n = 0;
    while (pw.pdown_seq !== 1'b1 && n < 5) begin @(negedge clk); n++; end
    n = 0;
    while (pw.pdown_seq === 1'b1 && n < 40) begin @(negedge clk); n++; end
    chk(8'(n), 8'(PDOWN_CYCLES), "pdown");
    chk({3'h0, pw.rc_osc_en, pw.xtal_osc_en, pw.core_reg_on, pw.slow_osc_en, pw.cpu_halt},
        {5'h0, lv == LEVEL_LIGHT, lv != LEVEL_DEEPEST, 1'b1}, "asleep");
    if (lv == LEVEL_DEEPEST) begin
      @(posedge clk); wake.timer_irq <= 1'b1;
      @(posedge clk); wake.timer_irq <= 1'b0;
      @(negedge clk); chk({7'h0, pw.rc_osc_en}, 8'h00, "deepest timer");
    end
    @(posedge clk);
    if (lv == LEVEL_DEEPEST || !s) wake.port_irq <= 1'b1;
    else wake.timer_irq <= 1'b1;
    @(posedge clk); wake <= '0;
    @(negedge clk); chk({6'h0, pw.rc_osc_en, pw.sysclk_on_xtal}, 8'h02, "wake");
    n = 0;
    while (pw.sysclk_on_xtal !== 1'b1 && n < 30) begin @(negedge clk); n++; end
    chk({7'h0, pw.sysclk_on_xtal}, {7'h0, !s}, "clock after wake");
    chk({7'h0, pw.slow_trim_run}, {7'h0, !s}, "trim with crystal");
    $display("sleep %0d sel %0d done", lv, s);
  endtask
  task automatic crc_pulse(input logic [1:0] r, input int exp);
    int w;
    w = wd_cnt;
    @(posedge clk); crc_v <= 1'b1; crc_r <= r;
    @(posedge clk); crc_v <= 1'b0;
    cyc(3); chk(8'(wd_cnt - w), 8'(exp), "crc reset");
  endtask
  task automatic t_crc();
    logic [7:0] d;
    int w;
    wr(ADDR_RETENTION_CRC_CTL, 8'h01);
    t_sleep(LEVEL_DEEP, 1'b1);
    crc_pulse(2'h1, 1);
    rd(ADDR_RETENTION_CRC_CTL, d); chk(d, 8'h05, "crc result");
    wr(ADDR_RETENTION_CRC_CTL, 8'h0d);
    rd(ADDR_RETENTION_CRC_CTL, d); chk(d, 8'h05, "crc keep");
    wr(ADDR_RETENTION_CRC_CTL, 8'h00);
    rd(ADDR_RETENTION_CRC_CTL, d); chk(d, 8'h00, "crc clear");
    crc_pulse(2'h3, 0);
    w = wd_cnt;
    wr(ADDR_RETENTION_CRC_CTL, 8'h20);
    cyc(2); chk(8'(wd_cnt - w), 8'h01, "force");
    wr(ADDR_RETENTION_CRC_CTL, 8'h00);
    cyc(2); chk(8'(wd_cnt - w), 8'h01, "write 0 idle");
    $display("crc done");
  endtask
  task automatic t_slow();
    logic [7:0] d;
    @(posedge clk); slow <= 1'b1;
    cyc(4); rd(ADDR_SLEEP_MODE_STATUS, d); chk(d & 8'h01, 8'h01, "slow sync");
    @(posedge clk); slow <= 1'b0;
    wr(ADDR_SLEEP_MODE_CMD, 8'h84);
    cyc(4); rd(ADDR_SLEEP_MODE_STATUS, d); chk(d & 8'h80, 8'h80, "trim");
    @(posedge clk); slow_rc <= 1'b0;
    wr(ADDR_SLEEP_MODE_CMD, 8'h04);
    cyc(4); rd(ADDR_SLEEP_MODE_STATUS, d); chk(d & 8'h80, 8'h80, "trim held");
    @(posedge clk); slow_rc <= 1'b1;
    cyc(4); rd(ADDR_SLEEP_MODE_STATUS, d); chk(d & 8'h80, 8'h00, "trim follows");
    @(posedge clk); rst <= 1'b1; cause <= 2'h2;
    cyc(3); rst <= 1'b0;
    t_regs(8'h10);
    $display("slow done");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    cyc(5); cause <= 2'h1;
    cyc(5); rst <= 1'b0;
    t_regs(8'h08);
    t_idle();
    t_slow();
    for (int lv = 1; lv < 4; lv++) begin
      t_sleep(2'(lv), 1'b0);
      t_sleep(2'(lv), 1'b1);
    end
    t_crc();
    end_of_test();
  end
  initial begin
    #(50 * 20000);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire

// ==== tb/pmc_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module pmc_props (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Block ports
  input wire pmc_pkg::pmc_sfr_req_t i_sfr,
  input wire logic [7:0] o_sfr_rdata,
  input wire pmc_pkg::pmc_wake_t i_wake,
  input wire logic i_instr_retired,
  input wire logic i_xtal_stable,
  input wire logic i_slow_clk,
  input wire pmc_pkg::pmc_power_t o_power,
  input wire logic o_isr_defer,
  input wire logic o_wdog_reset
);
  import pmc_pkg::*;
  logic asleep;
  logic [PDOWN_CNT_W-1:0] pd_cnt;
  logic [PDOWN_CNT_W-1:0] next_pd_cnt;
  // ==========================================================
  // Helpers
  assign asleep = !o_power.rc_osc_en && !o_power.xtal_osc_en;
  always_comb begin
    next_pd_cnt = o_power.pdown_seq ? pd_cnt + 1'b1 : '0;
  end
  always_ff @(posedge i_core_clk) begin
    pd_cnt <= i_rst ? '0 : next_pd_cnt;
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  chk_trig_reads_zero: assert property (
    i_sfr.rd && i_sfr.addr == ADDR_SLEEP_TRIGGER_CTL |=> !o_sfr_rdata[TRIG_BIT])
    else $error("trigger bit read as one");
  chk_force_reset: assert property (
    i_sfr.wr && i_sfr.addr == ADDR_RETENTION_CRC_CTL && i_sfr.wdata[CRC_FORCE_BIT]
    |=> o_wdog_reset) else $error("no forced reset");
  chk_wdog_one_cycle: assert property (
    o_wdog_reset |=> !o_wdog_reset) else $error("reset request too long");
  chk_pdown_length: assert property (
    $fell(o_power.pdown_seq) |-> pd_cnt == PDOWN_CNT_W'(PDOWN_CYCLES) && asleep)
    else $error("power-down run wrong");
  chk_light_slow_osc: assert property (
    asleep && o_power.core_reg_on |-> o_power.slow_osc_en) else $error("slow osc off");
  chk_deepest_timer: assert property (
    asleep && !o_power.slow_osc_en && i_wake.timer_irq && !i_wake.port_irq && !i_wake.por
    |=> asleep) else $error("timer woke deepest sleep");
  chk_wake_on_rc: assert property (
    asleep && i_wake.port_irq |=> o_power.rc_osc_en && !o_power.sysclk_on_xtal && o_isr_defer)
    else $error("bad wake");
  chk_xtal_gate: assert property (
    $rose(o_power.sysclk_on_xtal) |-> i_xtal_stable) else $error("unstable crystal");
  chk_slow_sync: assert property (
    i_sfr.rd && i_sfr.addr == ADDR_SLEEP_MODE_STATUS |=> o_sfr_rdata[0] == $past(i_slow_clk, 3))
    else $error("slow clock status wrong");
  chk_defer_hold: assert property (
    o_isr_defer && !i_instr_retired |=> o_isr_defer) else $error("defer dropped early");
  chk_trim_xtal: assert property (
    o_power.slow_trim_run |-> o_power.xtal_osc_en) else $error("trim without crystal");
  cover property (o_wdog_reset);
  cover property (asleep ##1 !asleep);
  cover property ($fell(o_isr_defer));
endmodule
bind pmc_power_mode_ctl pmc_props u_props (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata),
  .i_wake(i_wake), .i_instr_retired(i_instr_retired), .i_xtal_stable(i_xtal_stable),
  .i_slow_clk(i_slow_clk), .o_power(o_power), .o_isr_defer(o_isr_defer),
  .o_wdog_reset(o_wdog_reset)
);
`default_nettype wire
